//--- src/sdm_params.svh
// timing counts and frame geometry for the serial dot matrix display controller
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// ---------------------------------------------------------------
// clock and frame geometry
// ---------------------------------------------------------------
`define SDM_CLK_PERIOD_NS 20
`define SDM_CLK_HZ 50000000
`define SDM_ROWS 16
`define SDM_COLS 16
`define SDM_DOTS 256

// ---------------------------------------------------------------
// link timing, in nanoseconds as printed, then in clock cycles
// ---------------------------------------------------------------
// shift clock at most 1 mhz: half period of 500 ns covers the 470 ns widths
`define SDM_SHIFT_PERIOD_NS 1000
`define SDM_SHIFT_HALF_CYC ((`SDM_SHIFT_PERIOD_NS / 2 + `SDM_CLK_PERIOD_NS - 1) / `SDM_CLK_PERIOD_NS)
`define SDM_PULSE_MIN_NS 470
`define SDM_LATCH_CYC ((`SDM_PULSE_MIN_NS + `SDM_CLK_PERIOD_NS - 1) / `SDM_CLK_PERIOD_NS)
`define SDM_CLK_SETUP_NS 220
`define SDM_SETUP_CYC ((`SDM_CLK_SETUP_NS + `SDM_CLK_PERIOD_NS - 1) / `SDM_CLK_PERIOD_NS)
// alternation signal at 70 hz: toggle every half period
`define SDM_ALT_HZ 70
`define SDM_ALT_HALF_CYC (`SDM_CLK_HZ / (2 * `SDM_ALT_HZ))

`endif

//--- src/sdm_pkg.sv
// types shared by the serial dot matrix display controller
package sdm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_HIGH,
    ST_LOW,
    ST_GAP,
    ST_LATCH,
    ST_POST
  } sdm_state_e;
endpackage

//--- src/sdm_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module sdm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // full and empty come straight from the fill count
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage has no reset: contents are only read behind the count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // fill count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule

//--- src/sdm_ctrl.sv
// controller that streams frames into a 16 by 16 serial dot matrix display
//
// Behaviour
// RL1: the display samples the serial dot bit on each falling edge of the shift clock.
// RL2: the display shows the shifted pattern on each rising edge of the latch strobe.
// RL3: each serial bit is one dot, 1 lighting it and 0 leaving it dark.
// RL4: the controller drives an alternation signal that flips polarity at about 70 hz.
// RL5: dots are numbered column by column, dots 1 to 16 forming the first column top down.
// RL6: even dots go out first ending with dot 256, then odd dots ending with dot 255.
// RL7: all display inputs stay low until the display is powered and drop before it is off; the code drops them three clocks after the supply pin falls.
// RL8: frame start is raised once per frame alongside the first data bit.
`timescale 1ns/1ns
`include "sdm_params.svh"
module sdm_ctrl #(
  parameter int ALT_HALF_CYC = `SDM_ALT_HALF_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // column words: bit 0 is the top row, first word is the leftmost column
  input wire logic i_col_valid,
  input wire logic [`SDM_ROWS-1:0] i_col_data,
  output logic o_col_ready,
  // display supply status pin
  input wire logic i_supply_on,
  // status
  output logic o_busy,
  output logic o_frame_done,
  // display pins
  output logic o_dot_shift_clock,
  output logic o_row_latch_strobe,
  output logic o_frame_start_pulse,
  output logic o_serial_dot_in,
  output logic o_lc_alternation
);
  localparam logic [4:0] HALF_LAST = 5'(`SDM_SHIFT_HALF_CYC - 1);
  localparam logic [4:0] SETUP_LAST = 5'(`SDM_SETUP_CYC - 1);
  localparam logic [4:0] LATCH_LAST = 5'(`SDM_LATCH_CYC - 1);
  localparam logic [3:0] COL_LAST = 4'(`SDM_COLS - 1);

  sdm_pkg::sdm_state_e state;
  sdm_pkg::sdm_state_e next_state;
  logic [`SDM_DOTS-1:0] frame;
  logic [3:0] col_cnt;
  logic [7:0] bit_idx;
  logic [7:0] cur_dot;
  logic [4:0] timer;
  logic timer_done;
  logic [4:0] timer_last;
  logic [1:0] supply_sync;
  logic powered;
  logic fifo_valid;
  logic [`SDM_ROWS-1:0] fifo_data;
  logic pop;
  logic [$clog2(ALT_HALF_CYC)-1:0] alt_cnt;

  // ---------------------------------------------------------------
  // input staging
  // ---------------------------------------------------------------
  sdm_fifo #(
    .WIDTH(`SDM_ROWS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_col_valid),
    .i_in_data(i_col_data),
    .o_in_ready(o_col_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(pop)
  );

  // supply pin is asynchronous: two flops before use
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_sync <= 2'h0;
    end else begin
      supply_sync <= {supply_sync[0], i_supply_on};
    end
  end
  assign powered = supply_sync[1];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // the fifo drains only while loading, so a busy link back-pressures the source
  assign pop = (state == sdm_pkg::ST_LOAD) && fifo_valid && powered;
  // even dots (second common group) first, then odd ones: dot = 2*k+1 then 2*k
  assign cur_dot = {bit_idx[6:0], ~bit_idx[7]}; // RL6

  always_comb begin
    unique case (state)
      sdm_pkg::ST_HIGH, sdm_pkg::ST_LOW: timer_last = HALF_LAST;
      sdm_pkg::ST_LATCH: timer_last = LATCH_LAST;
      default: timer_last = SETUP_LAST;
    endcase
  end
  assign timer_done = (timer == timer_last);

  always_comb begin
    next_state = state;
    unique case (state)
      sdm_pkg::ST_IDLE: if (fifo_valid) next_state = sdm_pkg::ST_LOAD;
      sdm_pkg::ST_LOAD: if (pop && col_cnt == COL_LAST) next_state = sdm_pkg::ST_HIGH;
      sdm_pkg::ST_HIGH: if (timer_done) next_state = sdm_pkg::ST_LOW;
      sdm_pkg::ST_LOW: begin
        if (timer_done) begin
          next_state = (bit_idx == 8'hff) ? sdm_pkg::ST_GAP : sdm_pkg::ST_HIGH;
        end
      end
      sdm_pkg::ST_GAP: if (timer_done) next_state = sdm_pkg::ST_LATCH;
      sdm_pkg::ST_LATCH: if (timer_done) next_state = sdm_pkg::ST_POST;
      sdm_pkg::ST_POST: if (timer_done) next_state = sdm_pkg::ST_IDLE;
    endcase
    // losing the supply abandons the frame at once
    if (!powered) begin
      next_state = sdm_pkg::ST_IDLE; // RL7
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= sdm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // phase timer restarts on every state change
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer <= 5'h0;
    end else if (next_state != state || state == sdm_pkg::ST_IDLE) begin
      timer <= 5'h0;
    end else begin
      timer <= timer + 5'h1;
    end
  end

  // column and bit counters
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      col_cnt <= 4'h0;
      bit_idx <= 8'h0;
    end else if (state == sdm_pkg::ST_IDLE) begin
      col_cnt <= 4'h0;
      bit_idx <= 8'h0;
    end else begin
      if (pop) begin
        col_cnt <= col_cnt + 4'h1;
      end
      if (state == sdm_pkg::ST_LOW && next_state == sdm_pkg::ST_HIGH) begin
        bit_idx <= bit_idx + 8'h1;
      end
    end
  end

  // frame store: column c, row r lands on zero-based dot c*16+r
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame <= '0;
    end else if (pop) begin
      frame[col_cnt*`SDM_ROWS +: `SDM_ROWS] <= fifo_data; // RL5
    end
  end

  // ---------------------------------------------------------------
  // display pins
  // ---------------------------------------------------------------
  // clock and strobe follow the next state so they line up with it;
  // data and frame start trail by a cycle, still far inside setup and hold
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dot_shift_clock <= 1'b0;
      o_row_latch_strobe <= 1'b0;
      o_serial_dot_in <= 1'b0;
      o_frame_start_pulse <= 1'b0;
    end else begin
      o_dot_shift_clock <= (next_state == sdm_pkg::ST_HIGH);
      o_row_latch_strobe <= (next_state == sdm_pkg::ST_LATCH);
      o_serial_dot_in <= (state == sdm_pkg::ST_HIGH || state == sdm_pkg::ST_LOW)
                         && powered && frame[cur_dot]; // RL3
      o_frame_start_pulse <= (state == sdm_pkg::ST_HIGH || state == sdm_pkg::ST_LOW)
                             && powered && bit_idx == 8'h0; // RL8
    end
  end

  // free-running alternation, held low while the display is unpowered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_cnt <= '0;
      o_lc_alternation <= 1'b0;
    end else if (!powered) begin
      alt_cnt <= '0;
      o_lc_alternation <= 1'b0; // RL7
    end else if (alt_cnt == ($clog2(ALT_HALF_CYC))'(ALT_HALF_CYC - 1)) begin
      alt_cnt <= '0;
      o_lc_alternation <= ~o_lc_alternation; // RL4
    end else begin
      alt_cnt <= alt_cnt + 1'b1;
    end
  end

  // status
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_frame_done <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_frame_done <= (state == sdm_pkg::ST_POST) && timer_done && powered;
      // taken from the next state so busy still lines up with the state register
      o_busy <= (next_state != sdm_pkg::ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_DOT_VALUE: assert property ( // RL3
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == sdm_pkg::ST_LOW && powered && $past(powered)) |-> o_serial_dot_in == frame[cur_dot])
    else $error("serial dot does not match frame bit");

  AST_ALT_TOGGLE: assert property ( // RL4
    @(posedge i_clk) disable iff (!i_rst_n)
    (powered && alt_cnt == ($clog2(ALT_HALF_CYC))'(ALT_HALF_CYC - 1))
    |=> (o_lc_alternation != $past(o_lc_alternation)))
    else $error("alternation did not toggle at half period");

  AST_COLUMN_MAP: assert property ( // RL5
    @(posedge i_clk) disable iff (!i_rst_n)
    pop |=> frame[$past(col_cnt)*`SDM_ROWS +: `SDM_ROWS] == $past(fifo_data))
    else $error("column word not stored at its dots");

  AST_FIRST_DOT: assert property ( // RL6
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == sdm_pkg::ST_LOAD && next_state == sdm_pkg::ST_HIGH) |=> cur_dot == 8'h01)
    else $error("frame did not open with dot 2");

  AST_LAST_DOT: assert property ( // RL6
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == sdm_pkg::ST_LOW && next_state == sdm_pkg::ST_GAP) |-> cur_dot == 8'hfe)
    else $error("frame did not close with dot 255");

  AST_POWER_OFF: assert property ( // RL7
    @(posedge i_clk) disable iff (!i_rst_n)
    (!powered ##1 !powered) |-> !o_dot_shift_clock && !o_row_latch_strobe
    && !o_serial_dot_in && !o_frame_start_pulse && !o_lc_alternation)
    else $error("display pins driven while unpowered");

  AST_FRAME_START: assert property ( // RL8
    @(posedge i_clk) disable iff (!i_rst_n)
    (powered && state == sdm_pkg::ST_HIGH && bit_idx == 8'h0 && timer_done)
    |-> o_frame_start_pulse ##1 o_frame_start_pulse)
    else $error("frame start not held over first falling edge");

  AST_FRAME_START_ONCE: assert property ( // RL8
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == sdm_pkg::ST_HIGH && bit_idx != 8'h0 && timer == 5'h1) |-> !o_frame_start_pulse)
    else $error("frame start raised past the first bit");

  AST_LATCH_AFTER_SHIFT: assert property ( // RL2
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_row_latch_strobe) |-> $past(state) == sdm_pkg::ST_GAP)
    else $error("latch strobe raised outside the frame end");
endmodule

//--- sim/sdm_display_model.sv
// behavioural model of the 16 by 16 serial dot matrix display input
`timescale 1ns/1ns
module sdm_display_model (
  // display pins
  input wire logic i_dot_shift_clock,
  input wire logic i_row_latch_strobe,
  input wire logic i_frame_start_pulse,
  input wire logic i_serial_dot_in,
  input wire logic i_lc_alternation,
  // observation
  output logic [255:0] o_shown,
  output logic [15:0] o_bits,
  output logic [15:0] o_starts
);
  logic [255:0] shifted = '0;
  logic [255:0] shown = '0;
  logic [15:0] k = '0;
  logic [15:0] idx = '0;
  logic [15:0] bits = '0;
  logic [15:0] starts = '0;
  // each observed value has a single driver
  assign o_shown = shown;
  assign o_bits = bits;
  assign o_starts = starts;
  // one dot per falling edge; frame start realigns the bit sequence
  always @(negedge i_dot_shift_clock) begin
    idx = i_frame_start_pulse ? 16'h0000 : k;
    if (i_frame_start_pulse) begin
      starts = starts + 16'h0001;
    end
    // even dots first, then odd dots; zero-based dot is column*16+row
    if (idx < 16'h0080) begin
      shifted[2 * idx + 1] = i_serial_dot_in;
    end else begin
      shifted[2 * (idx - 16'h0080)] = i_serial_dot_in;
    end
    k = idx + 16'h0001;
  end
  // the whole pattern becomes visible at the latch rise
  always @(posedge i_row_latch_strobe) begin
    shown = shifted;
    bits = k;
  end
endmodule

//--- sim/tb.sv
// self-checking bench for the serial dot matrix display controller
`timescale 1ns/1ns
module tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_col_valid = 1'b0;
  logic [15:0] i_col_data = 16'h0000;
  logic i_supply_on = 1'b0;
  logic o_col_ready, o_busy, o_frame_done, sck, lat, fsp, sdi, alt;
  logic [255:0] shown;
  logic [255:0] expect_dots;
  logic [15:0] bits, starts, s0;
  int err_total = 0;
  int n_checks = 0;
  // 20 ns system clock
  always #10 i_clk = ~i_clk;
  // short alternation period keeps the run small
  sdm_ctrl #(.ALT_HALF_CYC(64), .FIFO_DEPTH(16)) sdm_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_col_valid(i_col_valid), .i_col_data(i_col_data), .o_col_ready(o_col_ready),
    .i_supply_on(i_supply_on), .o_busy(o_busy), .o_frame_done(o_frame_done),
    .o_dot_shift_clock(sck), .o_row_latch_strobe(lat), .o_frame_start_pulse(fsp),
    .o_serial_dot_in(sdi), .o_lc_alternation(alt));
  sdm_display_model sdm_display_model_i (.i_dot_shift_clock(sck), .i_row_latch_strobe(lat),
    .i_frame_start_pulse(fsp), .i_serial_dot_in(sdi), .i_lc_alternation(alt),
    .o_shown(shown), .o_bits(bits), .o_starts(starts));
  // ----------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------
  task automatic chk_vec(input logic [255:0] got, input logic [255:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic give_up(input string msg);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
    test_done();
  endtask
  // all display pins idle low
  task automatic chk_idle(input string msg);
    chk_vec({251'd0, sck, lat, fsp, sdi, alt}, 256'd0, msg);
  endtask
  // ----------------------------------------------------------
  // stimulus helpers, entered and left at a falling edge
  // ----------------------------------------------------------
  // valid stays up across words so it is never lowered and raised in one step
  task automatic push_frame(input logic [15:0] seed);
    int c;
    int n;
    i_col_valid = 1'b1;
    for (c = 0; c < 16; c++) begin
      i_col_data = seed ^ {4{c[3:0]}};
      expect_dots[c * 16 +: 16] = i_col_data;
      for (n = 0; n < 40000 && o_col_ready !== 1'b1; n++) begin
        @(negedge i_clk);
      end
      if (n == 40000) begin
        give_up("column word never taken");
      end
      @(negedge i_clk);
    end
    i_col_valid = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 20000 && o_frame_done !== 1'b1; n++) begin
      @(negedge i_clk);
    end
    if (n == 20000) begin
      give_up("frame never completed");
    end
    @(negedge i_clk);
  endtask
  task automatic power(input logic on);
    i_supply_on = on;
    repeat (4) @(negedge i_clk);
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    chk_idle("pins not idle after reset");
    chk_vec(256'({o_col_ready, o_busy}), 256'd2, "column port state after reset");
  endtask
  task automatic t_frame();
    power(1'b1);
    s0 = starts;
    push_frame(16'ha5c3);
    wait_done();
    chk_vec(shown, expect_dots, "displayed pattern");
    chk_vec(256'(bits), 256'd256, "bits per latch");
    chk_vec(256'(starts - s0), 256'd1, "frame start count");
  endtask
  task automatic t_fill();
    power(1'b0);
    push_frame(16'h0ff0);
    chk_vec(256'(o_col_ready), 256'd0, "fifo full not refused");
    chk_idle("pins driven while unpowered");
    power(1'b1);
    wait_done();
    chk_vec(shown, expect_dots, "pattern after fill");
  endtask
  task automatic t_abort();
    push_frame(16'hffff);
    repeat (2000) @(negedge i_clk);
    power(1'b0);
    chk_idle("pins driven after supply loss");
    chk_vec(256'(o_busy), 256'd0, "busy after abort");
  endtask
  task automatic t_alt();
    int n;
    int flips;
    logic last;
    power(1'b1);
    flips = 0;
    last = alt;
    for (n = 0; n < 640; n++) begin
      @(negedge i_clk);
      flips += (alt !== last) ? 1 : 0;
      last = alt;
    end
    chk_vec(256'(flips >= 9 && flips <= 11), 256'd1, "alternation rate");
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_frame();
    t_fill();
    t_abort();
    t_alt();
    test_done();
  end
endmodule
